// >>> core/stepper_pkg.sv
package stepper_pkg;

  // ------------------------------------------------------------
  // Clock and boost timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Timing network figures: t_on = 0.55 * R * C
  localparam longint unsigned BOOST_FACTOR_PCT = 55;
  localparam longint unsigned BOOST_RT_OHM = 47000;
  localparam longint unsigned BOOST_CT_PF = 10000;
  // pct/100 and pF*ohm = 1e-12 s = 1e-3 ns
  localparam longint unsigned BOOST_TON_NS =
    (BOOST_FACTOR_PCT * BOOST_RT_OHM * BOOST_CT_PF) / 64'd100000;
  localparam longint unsigned BOOST_CYCLES_L =
    BOOST_TON_NS / CLK_PERIOD_NS;
  localparam int BOOST_W = 16;
  localparam logic [BOOST_W-1:0] BOOST_CYCLES_DEF =
    BOOST_CYCLES_L[BOOST_W-1:0];

  // ------------------------------------------------------------
  // Phase table
  // ------------------------------------------------------------
  localparam int PHASE_W = 3;
  localparam int DRIVE_W = 4;
  typedef logic [PHASE_W-1:0] phase_idx_t;
  // Drive bit positions
  localparam int DRV_A1 = 3;
  localparam int DRV_A2 = 2;
  localparam int DRV_B1 = 1;
  localparam int DRV_B2 = 0;
  localparam logic [DRIVE_W-1:0] DRIVE_OFF = 4'h0;
  localparam phase_idx_t PHASE_RESET = 3'h0;
  localparam phase_idx_t STEP_HALF = 3'h1;
  localparam phase_idx_t STEP_FULL = 3'h2;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_BOOST_LEN = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  // Status fields
  localparam int ST_PHASE_LSB = 0;
  localparam int ST_DRIVE_LSB = 4;
  localparam int ST_BOOST_A = 8;
  localparam int ST_BOOST_B = 9;
  localparam int ST_ZERO_A = 10;
  localparam int ST_ZERO_B = 11;
  localparam int ST_KILL = 12;
  localparam int ST_HALF = 13;
  localparam int ST_DIR = 14;

  // Input synchroniser reset level: open pins read high
  localparam logic [3:0] SYNC_RESET = 4'hF;

endpackage

// >>> core/boost_oneshot.sv
module boost_oneshot (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic trigger,
  input wire logic [stepper_pkg::BOOST_W-1:0] length,
  output logic active
);

  logic [stepper_pkg::BOOST_W-1:0] count_r;
  logic [stepper_pkg::BOOST_W-1:0] count_nxt;

  // Retrigger restarts the full interval
  assign count_nxt = trigger ? length :
    (count_r != '0) ? count_r - 1'b1 : count_r;
  assign active = (count_r != '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule // boost_oneshot

// >>> core/stepper_phase_sequencer.sv
// Operation
// (R01) One step per falling edge of advance_strobe, none on rising edges.
// (R02) half_step_select low gives half steps, high gives full steps.
// (R03) In half-step mode two strobe edges make one full step.
// (R04) Direction and size are sampled at the falling strobe edge.
// (R05) Controller keeps direction and mode settled around the strobe edge.
// (R06) rotation_sense picks forward or reverse traversal of the sequence.
// (R07) output_kill high forces all four drives off; sequence state kept.
// (R08) Unconnected logic inputs read as high.
// (R09) Reset initialises the sequence and holds all outputs off.
// (R10) A change of a phase pair triggers that phase's one-shot.
// (R11) Two independent one-shots share one timing setting.
// (R12) Boost lasts about 0.55 times R times C.
// (R13) Boost drops when the interval expires until the next change.
// (R14) Zero flags show which phase current is inhibited.
// (R15) Controller checks zero flags before half to full step switching.
// (R16) Complementary pairs; half-step states turn one pair fully off.
// (R17) Boost outputs forced off under output_kill or reset.
// (R18) Zero flag high exactly while its pair is fully off. Flags follow the sequence; they stay low under output_kill and reset. Here: low in reset only.
module stepper_phase_sequencer #(
  parameter logic [stepper_pkg::BOOST_W-1:0] BOOST_CYCLES =
    stepper_pkg::BOOST_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  // Controller pins
  input wire logic advance_strobe,
  input wire logic rotation_sense,
  input wire logic half_step_select,
  input wire logic output_kill,
  // Winding drives, boost outputs and zero flags
  output logic winding_a_first_drive,
  output logic winding_a_second_drive,
  output logic winding_b_first_drive,
  output logic winding_b_second_drive,
  output logic boost_out_phase_a,
  output logic boost_out_phase_b,
  output logic phase_a_zero_flag,
  output logic phase_b_zero_flag,
  // Avalon-MM slave
  input wire logic [stepper_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ------------------------------------------------------------
  // Phase table decode
  // ------------------------------------------------------------
  // Even indices are full-step states, odd ones have one pair off
  function automatic logic [stepper_pkg::DRIVE_W-1:0] drive_of(
    input stepper_pkg::phase_idx_t idx
  );
    logic [stepper_pkg::DRIVE_W-1:0] d;
    d = stepper_pkg::DRIVE_OFF;
    unique case (idx)
      3'h0: d = 4'hA;
      3'h1: d = 4'h2;
      3'h2: d = 4'h6;
      3'h3: d = 4'h4;
      3'h4: d = 4'h5;
      3'h5: d = 4'h1;
      3'h6: d = 4'h9;
      3'h7: d = 4'h8;
    endcase
    return d; // R16
  endfunction

  function automatic logic pair_a_off(
    input logic [stepper_pkg::DRIVE_W-1:0] d
  );
    return !d[stepper_pkg::DRV_A1] && !d[stepper_pkg::DRV_A2];
  endfunction

  function automatic logic pair_b_off(
    input logic [stepper_pkg::DRIVE_W-1:0] d
  );
    return !d[stepper_pkg::DRV_B1] && !d[stepper_pkg::DRV_B2];
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [3:0] pins;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic strobe_d_r;

  assign pins = {advance_strobe, rotation_sense, half_step_select,
                 output_kill};

  // Reset to high so a floating pin never looks like a low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= stepper_pkg::SYNC_RESET; // R08
      sync2_r <= stepper_pkg::SYNC_RESET; // R08
      strobe_d_r <= 1'b1;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
      strobe_d_r <= sync2_r[3];
    end
  end

  logic strobe_s;
  logic dir_s;
  logic full_s;
  logic kill_s;
  logic strobe_fall;

  assign strobe_s = sync2_r[3];
  assign dir_s = sync2_r[2];
  assign full_s = sync2_r[1];
  assign kill_s = sync2_r[0];
  // Direction and mode are taken in the same cycle as the edge,
  // so the controller must settle them beforehand
  assign strobe_fall = strobe_d_r && !strobe_s; // R01 R04 R05

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  stepper_pkg::phase_idx_t phase_r;
  stepper_pkg::phase_idx_t phase_nxt;
  stepper_pkg::phase_idx_t step_size;
  stepper_pkg::phase_idx_t phase_moved;

  // Full step from a half state moves one place to regain a full
  // state; otherwise a full step skips the half state
  assign step_size = (!full_s || phase_r[0]) ?
    stepper_pkg::STEP_HALF : stepper_pkg::STEP_FULL; // R02 R03 R16
  assign phase_moved = dir_s ? phase_r + step_size :
    phase_r - step_size; // R06
  assign phase_nxt = strobe_fall ? phase_moved : phase_r; // R01

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= stepper_pkg::PHASE_RESET; // R09
    end else begin
      phase_r <= phase_nxt; // R07
    end
  end

  // ------------------------------------------------------------
  // Pair change triggers
  // ------------------------------------------------------------
  logic [stepper_pkg::DRIVE_W-1:0] drive_cur;
  logic [stepper_pkg::DRIVE_W-1:0] drive_next;
  logic trig_a;
  logic trig_b;

  assign drive_cur = drive_of(phase_r);
  assign drive_next = drive_of(phase_nxt);
  assign trig_a = drive_cur[stepper_pkg::DRV_A1] !=
      drive_next[stepper_pkg::DRV_A1] ||
    drive_cur[stepper_pkg::DRV_A2] !=
      drive_next[stepper_pkg::DRV_A2]; // R10
  assign trig_b = drive_cur[stepper_pkg::DRV_B1] !=
      drive_next[stepper_pkg::DRV_B1] ||
    drive_cur[stepper_pkg::DRV_B2] !=
      drive_next[stepper_pkg::DRV_B2]; // R10

  // ------------------------------------------------------------
  // One-shots
  // ------------------------------------------------------------
  logic [stepper_pkg::BOOST_W-1:0] boost_len_r;
  logic [1:0] trig;
  logic [1:0] shot_active;

  assign trig = {trig_b, trig_a};

  // Both timers run from the one shared length setting
  for (genvar g = 0; g < 2; g++) begin : g_shot
    boost_oneshot u_shot (
      .clk(clk),
      .rst_n(rst_n),
      .trigger(trig[g]),
      .length(boost_len_r),
      .active(shot_active[g])
    ); // R11 R12 R13
  end

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  logic [stepper_pkg::DRIVE_W-1:0] drive_gated;
  logic [1:0] boost_gated;
  logic [stepper_pkg::DRIVE_W-1:0] drive_r;
  logic [1:0] boost_r;
  logic [1:0] zero_r;

  assign drive_gated = kill_s ? stepper_pkg::DRIVE_OFF :
    drive_next; // R07
  assign boost_gated = kill_s ? 2'h0 : shot_active; // R17 R13

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= stepper_pkg::DRIVE_OFF; // R09
      boost_r <= 2'h0; // R17
      zero_r <= 2'h0;
    end else begin
      drive_r <= drive_gated;
      boost_r <= boost_gated;
      zero_r <= {pair_b_off(drive_next),
                 pair_a_off(drive_next)}; // R14 R18
    end
  end

  assign winding_a_first_drive = drive_r[stepper_pkg::DRV_A1];
  assign winding_a_second_drive = drive_r[stepper_pkg::DRV_A2];
  assign winding_b_first_drive = drive_r[stepper_pkg::DRV_B1];
  assign winding_b_second_drive = drive_r[stepper_pkg::DRV_B2];
  assign boost_out_phase_a = boost_r[0];
  assign boost_out_phase_b = boost_r[1];
  // Flags track the sequence, not output_kill
  assign phase_a_zero_flag = zero_r[0];
  assign phase_b_zero_flag = zero_r[1];

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // Fixed one wait state: every access ends at the second edge
  logic ack_r;
  logic req;
  logic hit_len;
  logic hit_status;
  logic [31:0] status_word;
  logic [31:0] read_mux;
  logic [31:0] readdata_r;
  logic len_we;

  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_r;
  assign hit_len = avs_address == stepper_pkg::REG_BOOST_LEN;
  assign hit_status = avs_address == stepper_pkg::REG_STATUS;
  assign len_we = avs_write && ack_r && hit_len;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[stepper_pkg::ST_PHASE_LSB +: stepper_pkg::PHASE_W] =
      phase_r;
    status_word[stepper_pkg::ST_DRIVE_LSB +: stepper_pkg::DRIVE_W] =
      drive_r;
    status_word[stepper_pkg::ST_BOOST_A] = boost_r[0];
    status_word[stepper_pkg::ST_BOOST_B] = boost_r[1];
    status_word[stepper_pkg::ST_ZERO_A] = zero_r[0];
    status_word[stepper_pkg::ST_ZERO_B] = zero_r[1];
    status_word[stepper_pkg::ST_KILL] = kill_s;
    status_word[stepper_pkg::ST_HALF] = !full_s;
    status_word[stepper_pkg::ST_DIR] = dir_s;
  end

  assign read_mux = hit_len ? {{(32 - stepper_pkg::BOOST_W){1'b0}},
                               boost_len_r} :
    hit_status ? status_word : stepper_pkg::READ_UNMAPPED;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0000_0000;
      // Preset length comes from the build, software may override
      boost_len_r <= BOOST_CYCLES; // R12
    end else begin
      ack_r <= req && !ack_r;
      if (avs_read && !ack_r) begin
        readdata_r <= read_mux;
      end
      if (len_we) begin
        boost_len_r <= avs_writedata[stepper_pkg::BOOST_W-1:0]; // R12
      end
    end
  end

  assign avs_readdata = readdata_r;

endmodule // stepper_phase_sequencer

// >>> bench/stepper_phase_sequencer_checker.sv
module stepper_phase_sequencer_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic advance_strobe,
  input wire logic output_kill,
  input wire logic winding_a_first_drive,
  input wire logic winding_a_second_drive,
  input wire logic winding_b_first_drive,
  input wire logic winding_b_second_drive,
  input wire logic boost_out_phase_a,
  input wire logic boost_out_phase_b,
  input wire logic phase_a_zero_flag,
  input wire logic phase_b_zero_flag,
  input wire logic [stepper_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [1:0] pa = {winding_a_first_drive, winding_a_second_drive};
  wire [1:0] pb = {winding_b_first_drive, winding_b_second_drive};
  wire len_wr = avs_write && !avs_waitrequest &&
    avs_address == stepper_pkg::REG_BOOST_LEN;
  logic [15:0] len_r;
  logic [15:0] run_r;
  logic [1:0] pa_r;
  // Boost run length; a change of pair A restarts the count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_r <= stepper_pkg::BOOST_CYCLES_DEF;
      run_r <= 16'h0000;
      pa_r <= 2'h0;
    end else begin
      if (len_wr) begin
        len_r <= avs_writedata[15:0];
      end
      pa_r <= pa;
      run_r <= (boost_out_phase_a && pa == pa_r) ? run_r + 16'h0001
        : 16'h0000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Kill passes a two-flop synchroniser first, hence the long windows
  sequence kill_held; output_kill [*5]; endsequence
  sequence kill_clear; !output_kill [*6]; endsequence
  sequence bus_req; $rose(avs_read || avs_write); endsequence
  a_kill_drives: assert property (kill_held |-> {pa, pb} == 4'h0)
    else $error("drives on under kill");
  a_kill_boost: assert property (kill_held |->
    !boost_out_phase_a && !boost_out_phase_b) else $error("boost under kill");
  a_pair_legal: assert property (!(&pa) && !(&pb))
    else $error("both outputs of a pair on");
  a_zero_flag_a: assert property (kill_clear |->
    phase_a_zero_flag == (pa == 2'h0)) else $error("zero flag A wrong");
  a_zero_flag_b: assert property (kill_clear |->
    phase_b_zero_flag == (pb == 2'h0)) else $error("zero flag B wrong");
  a_bus_wait: assert property (bus_req |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("wait state wrong");
  a_idle_hold: assert property ((advance_strobe && !output_kill) [*8]
    |-> $stable({pa, pb})) else $error("drives moved without a fall");
  a_boost_start: assert property ((pa_r != 2'h0 && pa != 2'h0 &&
    pa != pa_r && len_r != 16'h0000 && !output_kill) |->
    ##[1:2] boost_out_phase_a) else $error("boost A not triggered");
  a_boost_max: assert property (run_r <= len_r)
    else $error("boost A too long");
  a_boost_end: assert property (($fell(boost_out_phase_a) &&
    !output_kill && !$past(output_kill, 4)) |-> run_r == len_r)
    else $error("boost A ended early");
endmodule // stepper_phase_sequencer_checker

// >>> bench/step_controller_model.sv
module step_controller_model (
  input wire logic clk,
  output logic advance_strobe,
  output logic rotation_sense,
  output logic half_step_select
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    advance_strobe = 1'b1;
    rotation_sense = 1'b1;
    half_step_select = 1'b1;
  end
  // Sense and mode settle 4 cycles before the fall and hold past it
  task automatic step(input logic fwd, input logic full, input int gap);
    @(posedge clk);
    rotation_sense <= fwd;
    half_step_select <= full;
    repeat (4) @(posedge clk);
    advance_strobe <= 1'b0;
    repeat (gap) @(posedge clk);
    advance_strobe <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask
endmodule // step_controller_model

// >>> bench/stepper_phase_sequencer_bench.sv
module stepper_phase_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic output_kill = 1'b1;
  logic [stepper_pkg::ADDR_W-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic advance_strobe, rotation_sense, half_step_select;
  logic winding_a_first_drive, winding_a_second_drive;
  logic winding_b_first_drive, winding_b_second_drive;
  logic boost_out_phase_a, boost_out_phase_b, avs_waitrequest;
  logic phase_a_zero_flag, phase_b_zero_flag;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [2:0] idx = 3'h0;
  int n_errors = 0;
  int check_count = 0;
  int seed = 80;
  int r;
  logic [3:0] seq_tab [8] = '{4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1, 4'h9, 4'h8};
  wire [3:0] drv = {winding_a_first_drive, winding_a_second_drive,
    winding_b_first_drive, winding_b_second_drive};
  always #5 clk = ~clk;
  step_controller_model step_controller_model_inst (
    .clk, .advance_strobe, .rotation_sense, .half_step_select);
  stepper_phase_sequencer stepper_phase_sequencer_inst (
    .clk, .rst_n, .advance_strobe, .rotation_sense, .half_step_select,
    .output_kill, .winding_a_first_drive, .winding_a_second_drive,
    .winding_b_first_drive, .winding_b_second_drive, .boost_out_phase_a,
    .boost_out_phase_b, .phase_a_zero_flag, .phase_b_zero_flag,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  task automatic check(input string what, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) n_errors++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic outs(input logic kill, input logic [1:0] bst);
    logic [3:0] e;
    e = seq_tab[idx];
    check("drives", drv, kill ? 4'h0 : e);
    check("zero", {phase_a_zero_flag, phase_b_zero_flag},
      {e[3:2] == 2'h0, e[1:0] == 2'h0});
    check("boost", {boost_out_phase_a, boost_out_phase_b}, bst);
  endtask
  task automatic do_step(input logic fwd, full, kill, input int gap);
    logic [3:0] old;
    logic [1:0] bst;
    old = seq_tab[idx];
    step_controller_model_inst.step(fwd, full, gap);
    // Full step from a half state only reaches the next full state
    idx = (full && !idx[0]) ? (fwd ? idx + 3'h2 : idx - 3'h2)
      : (fwd ? idx + 3'h1 : idx - 3'h1);
    bst = kill ? 2'h0 : {old[3:2] != seq_tab[idx][3:2],
      old[1:0] != seq_tab[idx][1:0]};
    repeat (6) @(posedge clk);
    outs(kill, bst);
    repeat (24) @(posedge clk);
    outs(kill, 2'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    check("reset_outs", {drv, phase_a_zero_flag, phase_b_zero_flag}, 0);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, stepper_pkg::REG_BOOST_LEN, 32'h0);
    check("len_reset", rd, 32'(stepper_pkg::BOOST_CYCLES_DEF));
    // Short boost keeps the run brief; kill held so nothing triggers yet
    bus(1'b1, stepper_pkg::REG_BOOST_LEN, 32'h0000_0014);
    bus(1'b0, stepper_pkg::REG_BOOST_LEN, 32'h0);
    check("len", rd, 32'h0000_0014);
    bus(1'b0, 4'h8, 32'h0);
    check("unmapped", rd, 32'h0000_0000);
    output_kill <= 1'b0;
    repeat (40) @(posedge clk);
    check("drives_init", drv, 4'hA);
    do_step(1'b1, 1'b0, 1'b0, 3);
    do_step(1'b1, 1'b1, 1'b0, 3);
    do_step(1'b0, 1'b0, 1'b0, 3);
    do_step(1'b0, 1'b1, 1'b0, 3);
    repeat (40) begin
      r = $random(seed);
      do_step(r[0], r[1], 1'b0, 3 + r[3:2]);
    end
    output_kill <= 1'b1;
    repeat (6) @(posedge clk);
    repeat (3) begin
      r = $random(seed);
      do_step(r[0], r[1], 1'b1, 3);
    end
    // Sequence keeps counting under kill while the drives stay off
    bus(1'b0, stepper_pkg::REG_STATUS, 32'h0);
    check("status_phase", rd[stepper_pkg::ST_PHASE_LSB +: 3], idx);
    check("status_drv", rd[stepper_pkg::ST_DRIVE_LSB +: 4], 4'h0);
    check("status_kill", rd[stepper_pkg::ST_KILL], 1'b1);
    output_kill <= 1'b0;
    repeat (40) @(posedge clk);
    do_step(1'b0, 1'b1, 1'b0, 3);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    check("reset_all", {drv, boost_out_phase_a, boost_out_phase_b}, 0);
    rst_n <= 1'b1;
    idx = 3'h0;
    repeat (40) @(posedge clk);
    check("drives_rst", drv, 4'hA);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule // stepper_phase_sequencer_bench
bind stepper_phase_sequencer stepper_phase_sequencer_checker checker_inst (
  .clk, .rst_n, .advance_strobe, .output_kill, .winding_a_first_drive,
  .winding_a_second_drive, .winding_b_first_drive, .winding_b_second_drive,
  .boost_out_phase_a, .boost_out_phase_b, .phase_a_zero_flag,
  .phase_b_zero_flag, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_waitrequest);
